// ### logic/analog_acquisition_regs.sv
// Purpose: AHB-Lite register slice for converter and touch control
// Assumes: converter and touch logic run on hclk, done pulses 1 cycle
// Notes: zero wait state, every answer OKAY, unmapped reads zero
`timescale 1ns/1ps
module analog_acquisition_regs #(
  parameter int CONV_WIDTH  = 12,
  parameter int TOUCH_WIDTH = 14
) (
  // clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // ahb-lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output      logic                         hreadyout,
  output      logic                         hresp,
  output      logic [31:0]                  hrdata,
  // converter and touch results
  input  wire logic [CONV_WIDTH-1:0]        conv_result,
  input  wire logic [TOUCH_WIDTH-1:0]       touch_a_data,
  input  wire logic                         touch_a_end,
  input  wire logic                         touch_b_end,
  // control outputs
  output analog_regs_pkg::irq_enable_s      irq_enable,
  output      logic                         hot_write_parameter_bit,
  output analog_regs_pkg::touch_ctrl_s      touch_ctrl,
  output      logic [4:0]                   converter_input_selector,
  output analog_regs_pkg::source_route_s    source_route
);
  import analog_regs_pkg::*;

  if (CONV_WIDTH != 12 || TOUCH_WIDTH != 14) begin : g_check
    $error("result widths must match the register layout");
  end

  // data phase state
  logic                   dp_valid_reg;
  logic                   dp_write_reg;
  logic [7:0]             dp_idx_reg;
  logic                   addr_ok;
  logic                   wr_en;
  logic                   wr_irq;
  logic                   wr_conv;
  logic                   wr_touch;
  logic                   wr_sel;
  logic                   start_a_wr;
  logic                   start_b_wr;
  logic [TOUCH_WIDTH-1:0] touch_a_result_reg;
  logic [7:0]             rdata_byte;

  // address phase capture
  always_comb begin
    addr_ok = hsel && htrans[1] && (hsize == 3'h2) &&
              (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'h0;
      dp_write_reg <= 1'h0;
      dp_idx_reg   <= 8'h00;
    end else if (hready) begin
      dp_valid_reg <= addr_ok;
      dp_write_reg <= hwrite;
      dp_idx_reg   <= haddr[9:2];
    end
  end

  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;

  // write strobes, taken at the end of the data phase
  always_comb begin
    wr_en    = dp_valid_reg && dp_write_reg && hready;
    wr_irq   = wr_en && (dp_idx_reg == IDX_IRQ_EN);
    wr_conv  = wr_en && (dp_idx_reg == IDX_CONV_LOW);
    wr_touch = wr_en && (dp_idx_reg == IDX_TOUCH_CTRL);
    wr_sel   = wr_en && (dp_idx_reg == IDX_CHAN_SEL);
    start_a_wr = wr_touch && hwdata[BIT_A_START];
    start_b_wr = wr_touch && hwdata[BIT_B_START];
  end

  // interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable <= '0;
    end else if (wr_irq) begin
      irq_enable.ext_pin2_irq_wake_enable <= hwdata[BIT_EXT_PIN2];
      irq_enable.pin_change_irq_enable <= hwdata[BIT_PIN_CHANGE];
      irq_enable.third_timer_irq_enable <= hwdata[BIT_TIMER3];
    end
  end

  // write-only parameter bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hot_write_parameter_bit <= 1'h0;
    end else if (wr_conv) begin
      hot_write_parameter_bit <= hwdata[BIT_HOT_WRITE];
    end
  end

  // touch control, one process owns the whole struct
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      touch_ctrl.touch_a_power_down <= PD_RST;
      touch_ctrl.touch_b_power_down <= PD_RST;
      touch_ctrl.touch_a_conversion_start <= 1'h0;
      touch_ctrl.touch_b_conversion_start <= 1'h0;
      touch_ctrl.touch_a_conversion_done <= DONE_RST;
      touch_ctrl.touch_b_conversion_done <= DONE_RST;
    end else begin
      if (wr_touch) begin
        touch_ctrl.touch_a_power_down <= hwdata[BIT_A_PD];
        touch_ctrl.touch_b_power_down <= hwdata[BIT_B_PD];
      end
      // a new start beats the end of the old one
      if (start_a_wr) begin
        touch_ctrl.touch_a_conversion_start <= 1'h1;
      end else if (touch_a_end) begin
        touch_ctrl.touch_a_conversion_start <= 1'h0;
      end
      if (start_b_wr) begin
        touch_ctrl.touch_b_conversion_start <= 1'h1;
      end else if (touch_b_end) begin
        touch_ctrl.touch_b_conversion_start <= 1'h0;
      end
      // done flags, end pulse wins over a start clear
      if (touch_a_end) begin
        touch_ctrl.touch_a_conversion_done <= 1'h1;
      end else if (start_a_wr) begin
        touch_ctrl.touch_a_conversion_done <= 1'h0;
      end
      if (touch_b_end) begin
        touch_ctrl.touch_b_conversion_done <= 1'h1;
      end else if (start_b_wr) begin
        touch_ctrl.touch_b_conversion_done <= 1'h0;
      end
    end
  end

  // latest touch A result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      touch_a_result_reg <= '0;
    end else if (touch_a_end) begin
      touch_a_result_reg <= touch_a_data;
    end
  end

  // channel selector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_input_selector <= SEL_RST;
    end else if (wr_sel) begin
      converter_input_selector <= hwdata[SEL_LSB+:5];
    end
  end

  converter_source_decode u_decode (
    .hclk    (hclk),
    .hresetn (hresetn),
    .code    (converter_input_selector),
    .route   (source_route)
  );

  // read mux
  always_comb begin
    rdata_byte = 8'h00;
    case (dp_idx_reg)
      IDX_IRQ_EN: begin
        rdata_byte = {5'h00,
                      irq_enable.ext_pin2_irq_wake_enable,
                      irq_enable.pin_change_irq_enable,
                      irq_enable.third_timer_irq_enable};
      end
      IDX_CONV_LOW: begin
        rdata_byte = {conv_result[3:0], 4'h0};
      end
      IDX_CONV_HIGH: begin
        rdata_byte = conv_result[11:4];
      end
      IDX_TOUCH_LOW: begin
        rdata_byte = touch_a_result_reg[7:0];
      end
      IDX_TOUCH_HIGH: begin
        rdata_byte = {2'h0, touch_a_result_reg[13:8]};
      end
      IDX_TOUCH_CTRL: begin
        rdata_byte = {touch_ctrl.touch_a_power_down,
                      touch_ctrl.touch_a_conversion_done,
                      touch_ctrl.touch_a_conversion_start,
                      1'h0,
                      touch_ctrl.touch_b_power_down,
                      touch_ctrl.touch_b_conversion_done,
                      touch_ctrl.touch_b_conversion_start,
                      1'h0};
      end
      IDX_CHAN_SEL: begin
        rdata_byte = {converter_input_selector, 3'h0};
      end
      default: begin
        rdata_byte = 8'h00;
      end
    endcase
  end

  assign hrdata = (dp_valid_reg && !dp_write_reg) ?
                  {24'h000000, rdata_byte} : 32'h00000000;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_phase;
  assign rd_phase = dp_valid_reg && !dp_write_reg;

  property p_ext_pin2;
    wr_irq |=> irq_enable.ext_pin2_irq_wake_enable == $past(hwdata[2]);
  endproperty
  a_ext_pin2: assert property (p_ext_pin2)
    else $error("pin 2 enable did not take written value");

  property p_pin_change_hold;
    !wr_irq |=> $stable(irq_enable.pin_change_irq_enable);
  endproperty
  a_pin_change_hold: assert property (p_pin_change_hold)
    else $error("pin change enable moved without a write");

  property p_timer3;
    wr_irq ##1 !wr_irq |-> irq_enable.third_timer_irq_enable ==
      $past(hwdata[0]);
  endproperty
  a_timer3: assert property (p_timer3)
    else $error("timer 3 enable lost its written value");

  property p_conv_low;
    rd_phase && dp_idx_reg == IDX_CONV_LOW |->
      hrdata[7:4] == conv_result[3:0] && hrdata[3:0] == 4'h0;
  endproperty
  a_conv_low: assert property (p_conv_low)
    else $error("low result read wrong");

  property p_conv_high;
    rd_phase && dp_idx_reg == IDX_CONV_HIGH |->
      hrdata[7:0] == conv_result[11:4];
  endproperty
  a_conv_high: assert property (p_conv_high)
    else $error("high result read wrong");

  property p_hot_write;
    wr_conv |=> hot_write_parameter_bit == $past(hwdata[0]);
  endproperty
  a_hot_write: assert property (p_hot_write)
    else $error("parameter bit did not take write");

  sequence s_start_a;
    start_a_wr && !touch_a_end;
  endsequence

  sequence s_end_a;
    touch_a_end && !start_a_wr;
  endsequence

  property p_start_a;
    s_start_a |=> touch_ctrl.touch_a_conversion_start &&
      !touch_ctrl.touch_a_conversion_done;
  endproperty
  a_start_a: assert property (p_start_a)
    else $error("touch A start not begun");

  property p_end_a;
    s_end_a |=> !touch_ctrl.touch_a_conversion_start &&
      touch_ctrl.touch_a_conversion_done;
  endproperty
  a_end_a: assert property (p_end_a)
    else $error("touch A end not reflected");

  sequence s_end_b;
    touch_b_end && !start_b_wr;
  endsequence

  property p_end_b;
    s_end_b |=> !touch_ctrl.touch_b_conversion_start &&
      touch_ctrl.touch_b_conversion_done;
  endproperty
  a_end_b: assert property (p_end_b)
    else $error("touch B end not reflected");

  property p_b_done_stable;
    !touch_b_end && !start_b_wr |=>
      $stable(touch_ctrl.touch_b_conversion_done);
  endproperty
  a_b_done_stable: assert property (p_b_done_stable)
    else $error("touch B done moved without cause");

  property p_pd;
    wr_touch |=> touch_ctrl.touch_a_power_down == $past(hwdata[7]) &&
      touch_ctrl.touch_b_power_down == $past(hwdata[3]);
  endproperty
  a_pd: assert property (p_pd)
    else $error("power down bits did not take write");

  property p_reserved;
    rd_phase && dp_idx_reg == IDX_TOUCH_CTRL |->
      hrdata[4] == 1'h0 && hrdata[0] == 1'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits not zero");

  property p_touch_data;
    touch_a_end |=>
      touch_a_result_reg[13:8] == $past(touch_a_data[13:8]);
  endproperty
  a_touch_data: assert property (p_touch_data)
    else $error("touch A high bits not latest result");

  property p_sel;
    wr_sel |=> converter_input_selector == $past(hwdata[7:3]);
  endproperty
  a_sel: assert property (p_sel)
    else $error("selector did not take write");

endmodule // analog_acquisition_regs

// ### logic/analog_regs_pkg.sv
// Purpose: constants and carriers for the analog register slice
// Assumes: word-aligned registers, byte address is index times four
// Notes: register indices kept as printed
package analog_regs_pkg;

  // register indices
  localparam logic [7:0] IDX_IRQ_EN      = 8'hA9;
  localparam logic [7:0] IDX_CONV_LOW    = 8'hAA;
  localparam logic [7:0] IDX_CONV_HIGH   = 8'hAB;
  localparam logic [7:0] IDX_TOUCH_LOW   = 8'hAC;
  localparam logic [7:0] IDX_TOUCH_CTRL  = 8'hAD;
  localparam logic [7:0] IDX_CHAN_SEL    = 8'hAE;
  localparam logic [7:0] IDX_TOUCH_HIGH  = 8'hB2;

  // field positions
  localparam int BIT_EXT_PIN2   = 2;
  localparam int BIT_PIN_CHANGE = 1;
  localparam int BIT_TIMER3     = 0;
  localparam int BIT_HOT_WRITE  = 0;
  localparam int BIT_A_PD       = 7;
  localparam int BIT_A_START    = 5;
  localparam int BIT_B_PD       = 3;
  localparam int BIT_B_START    = 1;
  localparam int SEL_LSB        = 3;

  // reset values
  localparam logic       PD_RST   = 1'h1;
  localparam logic       DONE_RST = 1'h1;
  localparam logic [4:0] SEL_RST  = 5'h1F;

  // selector codes
  localparam logic [4:0] CODE_EXT_LOW_LAST  = 5'h0B;
  localparam logic [4:0] CODE_BANDGAP       = 5'h0C;
  localparam logic [4:0] CODE_AMPLIFIER     = 5'h0D;
  localparam logic [4:0] CODE_GROUND        = 5'h0E;
  localparam logic [4:0] CODE_EXT_HIGH_FIRST = 5'h0F;
  localparam logic [4:0] CODE_EXT_HIGH_LAST = 5'h15;
  localparam logic [4:0] CODE_QUARTER_VCC   = 5'h17;

  typedef struct packed {
    logic ext_pin2_irq_wake_enable;
    logic pin_change_irq_enable;
    logic third_timer_irq_enable;
  } irq_enable_s;

  typedef struct packed {
    logic touch_a_power_down;
    logic touch_a_conversion_start;
    logic touch_a_conversion_done;
    logic touch_b_power_down;
    logic touch_b_conversion_start;
    logic touch_b_conversion_done;
  } touch_ctrl_s;

  typedef struct packed {
    logic       external;
    logic [4:0] ext_index;
    logic       bandgap_reference;
    logic       amplifier_output;
    logic       ground;
    logic       quarter_supply;
    logic       reserved;
  } source_route_s;

endpackage

// ### logic/converter_source_decode.sv
// Purpose: turns the selector code into registered source routing
// Assumes: code comes from the channel select register
// Notes: route follows the code one clock later
`timescale 1ns/1ps
module converter_source_decode (
  // clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // selector
  input  wire logic [4:0]                     code,
  // route
  output analog_regs_pkg::source_route_s      route
);
  import analog_regs_pkg::*;

  source_route_s route_next;
  logic          ext_low;
  logic          ext_high;

  always_comb begin
    ext_low  = (code <= CODE_EXT_LOW_LAST);
    ext_high = (code >= CODE_EXT_HIGH_FIRST) &&
               (code <= CODE_EXT_HIGH_LAST);
    route_next                   = '0;
    route_next.external          = ext_low || ext_high;
    route_next.ext_index         = (ext_low || ext_high) ? code : 5'h00;
    route_next.bandgap_reference = (code == CODE_BANDGAP);
    route_next.amplifier_output  = (code == CODE_AMPLIFIER);
    route_next.ground            = (code == CODE_GROUND);
    route_next.quarter_supply    = (code == CODE_QUARTER_VCC);
    route_next.reserved          = !(ext_low || ext_high) &&
                                   (code != CODE_BANDGAP) &&
                                   (code != CODE_AMPLIFIER) &&
                                   (code != CODE_GROUND) &&
                                   (code != CODE_QUARTER_VCC);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route <= '0;
    end else begin
      route <= route_next;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_internal_route;
    (code == CODE_BANDGAP) |=> route.bandgap_reference && !route.external;
  endproperty
  a_internal_route: assert property (p_internal_route)
    else $error("bandgap code did not route the reference");

  property p_ext_high;
    (code == CODE_EXT_HIGH_FIRST) |=> route.external &&
      (route.ext_index == 5'h0F);
  endproperty
  a_ext_high: assert property (p_ext_high)
    else $error("code 01111 did not pick external input 15");

endmodule // converter_source_decode

// ### verif/analog_acquisition_regs_bench.sv
// Purpose: self-checking bench for the analog register slice
// Assumes: zero wait state slave, byte address is index times four
// Notes: drives bus, converter and touch inputs itself
`timescale 1ns/1ps
module analog_acquisition_regs_bench;
  import analog_regs_pkg::*;

  // clock and reset
  logic          hclk;
  logic          hresetn;
  // bus
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  logic          hready;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  // converter and touch
  logic [11:0]   conv_result;
  logic [13:0]   touch_a_data;
  logic          touch_a_end;
  logic          touch_b_end;
  // outputs
  irq_enable_s   irq_enable;
  logic          hot_write_parameter_bit;
  touch_ctrl_s   touch_ctrl;
  logic [4:0]    converter_input_selector;
  source_route_s source_route;
  // bookkeeping
  int            errors;
  int            samples_checked;
  logic [31:0]   rdata;
  logic [5:0]    exp_flags;

  assign hready = hreadyout;

  analog_acquisition_regs uut (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .hsel                     (hsel),
    .haddr                    (haddr),
    .htrans                   (htrans),
    .hwrite                   (hwrite),
    .hsize                    (hsize),
    .hwdata                   (hwdata),
    .hready                   (hready),
    .hreadyout                (hreadyout),
    .hresp                    (hresp),
    .hrdata                   (hrdata),
    .conv_result              (conv_result),
    .touch_a_data             (touch_a_data),
    .touch_a_end              (touch_a_end),
    .touch_b_end              (touch_b_end),
    .irq_enable               (irq_enable),
    .hot_write_parameter_bit  (hot_write_parameter_bit),
    .touch_ctrl               (touch_ctrl),
    .converter_input_selector (converter_input_selector),
    .source_route             (source_route)
  );

  // expected route flags from the selector code
  function automatic logic [5:0] route_flags(input logic [4:0] c);
    logic ext;
    logic inner;
    ext = (c <= 5'h0B) || (c >= 5'h0F && c <= 5'h15);
    inner = (c >= 5'h0C && c <= 5'h0E) || c == 5'h17;
    return {ext, c == 5'h0C, c == 5'h0D, c == 5'h0E, c == 5'h17,
            !(ext || inner)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer, master side
  task automatic xfer(input logic [7:0] idx, input logic wr,
                      input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdata = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input string what);
    xfer(idx, 1'b0, 32'h0);
    chk(what, exp, rdata);
  endtask

  task automatic pulse(input logic a, input logic b);
    touch_a_end <= a;
    touch_b_end <= b;
    @(posedge hclk);
    touch_a_end <= 1'b0;
    touch_b_end <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    repeat (4000) @(posedge hclk);
    errors++;
    wrap_up;
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    conv_result = 12'hABC;
    touch_a_data = 14'h0;
    touch_a_end = 1'b0;
    touch_b_end = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("hot bit reset", 32'h0, {31'h0, hot_write_parameter_bit});
    chk("route reset", 32'h1, {31'h0, source_route.reserved});
    rd(IDX_IRQ_EN, 32'h00, "irq reset");
    rd(IDX_TOUCH_CTRL, 32'hCC, "ctrl reset");
    rd(IDX_CHAN_SEL, 32'hF8, "sel reset");
    $display("test reset done");
    // interrupt enables
    wr(IDX_IRQ_EN, 8'hFF);
    #1;
    chk("irq out", 32'h7, {29'h0, irq_enable});
    rd(IDX_IRQ_EN, 32'h07, "irq all");
    for (int b = 0; b < 3; b++) begin
      wr(IDX_IRQ_EN, 8'h1 << b);
      #1;
      chk("irq one", 32'h1 << b, {29'h0, irq_enable});
    end
    $display("test irq done");
    // converter result and hot write bit
    rd(IDX_CONV_LOW, 32'hC0, "conv low");
    rd(IDX_CONV_HIGH, 32'hAB, "conv high");
    wr(IDX_CONV_LOW, 8'hFF);
    #1;
    chk("hot bit set", 32'h1, {31'h0, hot_write_parameter_bit});
    rd(IDX_CONV_LOW, 32'hC0, "conv low kept");
    wr(IDX_CONV_HIGH, 8'h00);
    conv_result <= 12'h35A;
    rd(IDX_CONV_HIGH, 32'h35, "conv high live");
    rd(IDX_CONV_LOW, 32'hA0, "conv low live");
    wr(IDX_CONV_LOW, 8'h00);
    #1;
    chk("hot bit clear", 32'h0, {31'h0, hot_write_parameter_bit});
    rd(8'hB0, 32'h0, "unmapped");
    $display("test converter done");
    // touch control
    wr(IDX_TOUCH_CTRL, 8'h22);
    #1;
    chk("ctrl out", 32'h12, {26'h0, touch_ctrl});
    rd(IDX_TOUCH_CTRL, 32'h22, "ctrl started");
    touch_a_data <= 14'h2A5C;
    pulse(1'b1, 1'b0);
    rd(IDX_TOUCH_CTRL, 32'h42, "ctrl a end");
    rd(IDX_TOUCH_LOW, 32'h5C, "touch low");
    rd(IDX_TOUCH_HIGH, 32'h2A, "touch high");
    pulse(1'b0, 1'b1);
    rd(IDX_TOUCH_CTRL, 32'h44, "ctrl b end");
    wr(IDX_TOUCH_CTRL, 8'hFF);
    rd(IDX_TOUCH_CTRL, 32'hAA, "ctrl all ones");
    wr(IDX_TOUCH_CTRL, 8'h00);
    rd(IDX_TOUCH_CTRL, 32'h22, "ctrl zero write");
    touch_a_data <= 14'h15A3;
    pulse(1'b1, 1'b1);
    rd(IDX_TOUCH_CTRL, 32'h44, "ctrl both end");
    wr(IDX_TOUCH_LOW, 8'h00);
    rd(IDX_TOUCH_LOW, 32'hA3, "touch low ro");
    rd(IDX_TOUCH_HIGH, 32'h15, "touch high ro");
    $display("test touch done");
    // byte sized write is dropped
    hsize <= 3'h0;
    wr(IDX_CHAN_SEL, 8'h00);
    hsize <= 3'h2;
    rd(IDX_CHAN_SEL, 32'hF8, "sel byte write");
    // selector codes and routing, reserved codes never written
    for (int c = 0; c < 32; c++) begin
      if (c == 5'h16 || c > 5'h17) begin
        continue;
      end
      wr(IDX_CHAN_SEL, {c[4:0], 3'h7});
      exp_flags = route_flags(c[4:0]);
      @(posedge hclk);
      #1;
      chk("sel out", 32'(c), {27'h0, converter_input_selector});
      chk("route", {26'h0, exp_flags}, {26'h0, source_route.external,
          source_route.bandgap_reference, source_route.amplifier_output,
          source_route.ground, source_route.quarter_supply,
          source_route.reserved});
      if (exp_flags[5]) begin
        chk("ext index", 32'(c), {27'h0, source_route.ext_index});
      end
      rd(IDX_CHAN_SEL, {24'h0, c[4:0], 3'h0}, "sel read");
    end
    $display("test selector done");
    wrap_up;
  end
endmodule // analog_acquisition_regs_bench
